// ### src/adc_aux_pkg.sv
// package: register map, fields, routing codes and timing for the control block
// ========================================
// Operation
// - simultaneous start bit launches both converters together under software trigger
// - channel swap select bit one moves converter zero to a group by port field; converter one keeps its channel
// - swap: converter zero uses group 15, 0 or 2 by port field
// - one-shot and repeat convert extended pins in place of channels zero, one
// - extended field 00 none, 01 first pin input, 10 second pin input
// - extended field 11 routes selected channel out through first extended pin
// - amplifier mode converts second extended pin into selected channel register
// - reference connect bit zero disconnects the ladder from the reference pin
// - device sets conversion request bit when conversion completes
package adc_aux_pkg;
  // ========================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00; // converter zero: start, mode, channel
  localparam logic [7:0] OFF_CTRL1 = 8'h04; // converter one: same layout
  localparam logic [7:0] OFF_CFG = 8'h08;   // extended field, reference connect
  localparam logic [7:0] OFF_STAT = 8'h0C;  // busy and done flags
  localparam logic [7:0] OFF_RES0 = 8'h10;  // result of converter zero, last
  localparam logic [7:0] OFF_RES1 = 8'h14;  // result of converter one, last
  localparam logic [7:0] OFF_CFG2 = 8'h18;  // simultaneous start, swap, port field
  // ========================================
  // field positions
  localparam int CTL_CH_LSB = 0;   // channel i, 3 bits
  localparam int CTL_MODE_LSB = 3; // mode, 3 bits
  localparam int CTL_TRG = 7;      // external trigger select
  localparam int CTL_START = 6;    // own start flag
  localparam int CFG_PORT_LSB = 1; // second config: port select field, 2 bits
  localparam int CFG_SWAP = 4;     // second config: channel swap select
  localparam int CFG_REF = 5;      // first config: reference connect
  localparam int CFG_EXT_LSB = 6;  // first config: extended field, 2 bits
  localparam int CFG_SIM = 7;      // second config: simultaneous start pulse
  localparam int CONV_CYCLES = 33; // converter busy time in clocks
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_PIN0 = 2'h1;
  localparam logic [1:0] EXT_PIN1 = 2'h2;
  localparam logic [1:0] EXT_AMP = 2'h3;
  localparam logic [1:0] PORT_G15 = 2'h0;
  localparam logic [1:0] PORT_G0 = 2'h2;
  localparam logic [1:0] PORT_G2 = 2'h3;
  typedef enum logic [2:0] {
    MODE_ONESHOT = 3'h0, MODE_REPEAT = 3'h1, MODE_SWEEP = 3'h2,
    MODE_RSWEEP0 = 3'h3, MODE_RSWEEP1 = 3'h4
  } mode_t;
  // analog mux select presented to each converter
  typedef enum logic [2:0] {
    SRC_PLAIN = 3'h0, SRC_G15 = 3'h1, SRC_G0 = 3'h2, SRC_G2 = 3'h3,
    SRC_EXT0 = 3'h4, SRC_EXT1 = 3'h5
  } src_t;
  typedef struct packed {
    src_t src;
    logic [2:0] chan;
    logic [2:0] store_idx;
  } route_t;
endpackage

// ### src/adc_route.sv
// channel routing for one converter
`timescale 1ns/1ns
module adc_route
  import adc_aux_pkg::*;
(
  input wire logic [2:0] chan, // own channel select
  input wire mode_t mode, // own mode
  input wire logic swap, // swap active
  input wire logic is_zero, // this is converter zero
  input wire logic [1:0] port_sel, // port field of second config, used by converter zero
  input wire logic [1:0] ext_sel, // extended field
  output route_t route // resulting mux and store index
);
  // swap beats extended pins for both converters, so a swapped cross-check
  // never mixes in an extended pin; amplifier mode keeps the store index
  always_comb begin
    route.chan = chan;
    route.store_idx = chan;
    route.src = SRC_PLAIN;
    if (swap) begin
      if (is_zero) begin
        case (port_sel)
          PORT_G0: route.src = SRC_G0;
          PORT_G2: route.src = SRC_G2;
          default: route.src = SRC_G15;
        endcase
      end
    end else if (ext_sel == EXT_AMP) begin
      route.src = SRC_EXT1;
    end else if (mode == MODE_ONESHOT || mode == MODE_REPEAT) begin
      if (ext_sel == EXT_PIN0 && chan == 3'h0) begin
        route.src = SRC_EXT0;
      end else if (ext_sel == EXT_PIN1 && chan == 3'h1) begin
        route.src = SRC_EXT1;
      end
    end
  end
endmodule

// ### src/adc_aux_ctrl.sv
// control of two converters: simultaneous start, swap, pins, reference
`timescale 1ns/1ns
module adc_aux_ctrl
  import adc_aux_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES // converter busy time
)(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read valid
  input wire logic rready, // read ready
  input wire logic [9:0] conv_data0, // converter zero digital result
  input wire logic [9:0] conv_data1, // converter one digital result
  input wire logic ext_trig0, // converter zero external trigger pin
  input wire logic ext_trig1, // converter one external trigger pin
  output route_t route0, // mux select for converter zero
  output route_t route1, // mux select for converter one
  output logic conv_active0, // converter zero sampling
  output logic conv_active1, // converter one sampling
  output logic ladder_connect, // reference ladder switch
  output logic amp_out_en, // amplifier drives the first extended pin
  output logic pin0_analog, // first extended pin analog input
  output logic pin1_analog, // second extended pin analog input
  output logic irq0, // converter zero conversion done request
  output logic irq1 // converter one conversion done request
);
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] cfg;
    logic [7:0] cfg2;
    logic [1:0] busy;
    logic [1:0] done;
    logic [5:0] cnt0;
    logic [5:0] cnt1;
    logic [9:0] res0;
    logic [9:0] res1;
    logic [1:0] t0_s;
    logic [1:0] t1_s;
    logic [1:0] t_prev;
  } state_t;
  state_t r, n;
  route_t rt0, rt1;
  logic wr_fire, rd_fire;
  logic [1:0] trg_now;

  // ========================================
  // helpers
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
    merge = s[0] ? d[7:0] : old;
  endfunction

  function automatic logic is_one_pass(input logic [7:0] ctl);
    is_one_pass = (ctl[CTL_MODE_LSB +: 3] == MODE_ONESHOT) ||
                  (ctl[CTL_MODE_LSB +: 3] == MODE_SWEEP);
  endfunction

  // ========================================
  // routing
  adc_route u_route0 (
    .chan(r.ctl0[CTL_CH_LSB +: 3]),
    .mode(mode_t'(r.ctl0[CTL_MODE_LSB +: 3])),
    .swap(r.cfg2[CFG_SWAP]),
    .is_zero(1'b1),
    .port_sel(r.cfg2[CFG_PORT_LSB +: 2]),
    .ext_sel(r.cfg[CFG_EXT_LSB +: 2]),
    .route(rt0)
  );
  // converter one takes plain channel i under swap; swap does not move it
  adc_route u_route1 (
    .chan(r.ctl1[CTL_CH_LSB +: 3]),
    .mode(mode_t'(r.ctl1[CTL_MODE_LSB +: 3])),
    .swap(r.cfg2[CFG_SWAP]),
    .is_zero(1'b0),
    .port_sel(r.cfg2[CFG_PORT_LSB +: 2]),
    .ext_sel(r.cfg[CFG_EXT_LSB +: 2]),
    .route(rt1)
  );

  assign awready = !r.aw_got && !r.bvalid;
  assign wready = !r.w_got && !r.bvalid;
  assign arready = !r.rvalid;
  assign wr_fire = r.aw_got && r.w_got && !r.bvalid;
  assign rd_fire = arvalid && !r.rvalid;
  // trigger edges from synchronised pins, second stage only
  assign trg_now = {r.t1_s[1], r.t0_s[1]};

  // ========================================
  // next state
  always_comb begin
    n = r;
    n.t0_s = {r.t0_s[0], ext_trig0};
    n.t1_s = {r.t1_s[0], ext_trig1};
    n.t_prev = trg_now;
    if (awvalid && awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      n.w_got = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (r.bvalid && bready) n.bvalid = 1'b0;
    if (r.rvalid && rready) n.rvalid = 1'b0;
    // conversion engines: count down, store on completion
    if (r.busy[0]) begin
      if (r.cnt0 == 6'h01) begin
        n.busy[0] = 1'b0;
        n.res0 = conv_data0;
        n.done[0] = 1'b1;
        if (is_one_pass(r.ctl0)) n.ctl0[CTL_START] = 1'b0;
        else n.busy[0] = 1'b1;
        n.cnt0 = 6'(CONV_LEN);
      end else n.cnt0 = r.cnt0 - 6'h01;
    end
    if (r.busy[1]) begin
      if (r.cnt1 == 6'h01) begin
        n.busy[1] = 1'b0;
        n.res1 = conv_data1;
        n.done[1] = 1'b1;
        if (is_one_pass(r.ctl1)) n.ctl1[CTL_START] = 1'b0;
        else n.busy[1] = 1'b1;
        n.cnt1 = 6'(CONV_LEN);
      end else n.cnt1 = r.cnt1 - 6'h01;
    end
    // external trigger rising edges start a converter
    if (r.ctl0[CTL_TRG] && trg_now[0] && !r.t_prev[0] && !r.busy[0]) begin
      n.busy[0] = 1'b1;
      n.cnt0 = 6'(CONV_LEN);
    end
    if (r.ctl1[CTL_TRG] && trg_now[1] && !r.t_prev[1] && !r.busy[1]) begin
      n.busy[1] = 1'b1;
      n.cnt1 = 6'(CONV_LEN);
    end
    // register writes
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = 2'h0;
      case (r.aw_addr)
        OFF_CTRL0: begin
          n.ctl0 = merge(r.ctl0, r.w_data, r.w_strb);
          if (r.w_strb[0] && r.w_data[CTL_START] && !r.ctl0[CTL_TRG]) begin
            n.busy[0] = 1'b1;
            n.cnt0 = 6'(CONV_LEN);
          end
          if (r.w_strb[0] && !r.w_data[CTL_START]) n.busy[0] = 1'b0;
        end
        OFF_CTRL1: begin
          n.ctl1 = merge(r.ctl1, r.w_data, r.w_strb);
          if (r.w_strb[0] && r.w_data[CTL_START] && !r.ctl1[CTL_TRG]) begin
            n.busy[1] = 1'b1;
            n.cnt1 = 6'(CONV_LEN);
          end
          if (r.w_strb[0] && !r.w_data[CTL_START]) n.busy[1] = 1'b0;
        end
        OFF_CFG: n.cfg = merge(r.cfg, r.w_data, r.w_strb);
        OFF_CFG2: begin
          n.cfg2 = merge(r.cfg2, r.w_data, r.w_strb);
          n.cfg2[CFG_SIM] = 1'b0;
          // software trigger only; both engines start on the same edge
          if (r.w_strb[0] && r.w_data[CFG_SIM]) begin
            n.busy = 2'h3;
            n.cnt0 = 6'(CONV_LEN);
            n.cnt1 = 6'(CONV_LEN);
          end
        end
        OFF_STAT: begin
          // write one clears; a completion in this cycle wins over the clear
          if (r.w_strb[0]) begin
            if (r.w_data[0] && !(r.busy[0] && r.cnt0 == 6'h01)) n.done[0] = 1'b0;
            if (r.w_data[1] && !(r.busy[1] && r.cnt1 == 6'h01)) n.done[1] = 1'b0;
          end
        end
        OFF_RES0, OFF_RES1: ;
        default: n.bresp = 2'h2;
      endcase
    end
    // register reads
    if (rd_fire) begin
      n.rvalid = 1'b1;
      n.rresp = 2'h0;
      case (araddr)
        OFF_CTRL0: n.rdata = {24'h000000, r.ctl0};
        OFF_CTRL1: n.rdata = {24'h000000, r.ctl1};
        OFF_CFG: n.rdata = {24'h000000, r.cfg};
        OFF_CFG2: n.rdata = {24'h000000, 1'b0, r.cfg2[6:0]};
        OFF_STAT: n.rdata = {28'h0000000, r.busy, r.done};
        OFF_RES0: n.rdata = {22'h000000, r.res0};
        OFF_RES1: n.rdata = {22'h000000, r.res1};
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = 2'h2;
        end
      endcase
    end
    // the reference ladder cannot carry a conversion while disconnected
    if (!n.cfg[CFG_REF]) n.busy = 2'h0;
  end

  // ========================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  // ========================================
  // outputs
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign rvalid = r.rvalid;
  assign rresp = r.rresp;
  assign rdata = r.rdata;
  assign route0 = rt0;
  assign route1 = rt1;
  assign conv_active0 = r.busy[0];
  assign conv_active1 = r.busy[1];
  assign ladder_connect = r.cfg[CFG_REF];
  assign amp_out_en = r.cfg[CFG_EXT_LSB +: 2] == EXT_AMP;
  assign pin0_analog = r.cfg[CFG_EXT_LSB +: 2] == EXT_PIN0;
  assign pin1_analog = r.cfg[CFG_EXT_LSB +: 2] == EXT_PIN1 ||
                       r.cfg[CFG_EXT_LSB +: 2] == EXT_AMP;
  assign irq0 = r.done[0];
  assign irq1 = r.done[1];

  // ========================================
  // checks
  property p_sim_start;
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_fire && r.aw_addr == OFF_CFG2 && r.w_strb[0] &&
     r.w_data[CFG_SIM] && r.cfg[CFG_REF]) |=> (r.busy == 2'h3);
  endproperty
  a_sim_start: assert property (p_sim_start)
    else $error("simultaneous start did not start both");

  property p_swap_src;
    @(posedge aclk) disable iff (!aresetn)
    r.cfg2[CFG_SWAP] |-> (rt0.src != SRC_PLAIN && rt1.src == SRC_PLAIN);
  endproperty
  a_swap_src: assert property (p_swap_src)
    else $error("swap routing wrong");

  property p_swap_g2;
    @(posedge aclk) disable iff (!aresetn)
    (r.cfg2[CFG_SWAP] && r.cfg2[2:1] == PORT_G2) |-> rt0.src == SRC_G2;
  endproperty
  a_swap_g2: assert property (p_swap_g2)
    else $error("group two not selected");

  property p_noswap;
    @(posedge aclk) disable iff (!aresetn)
    (!r.cfg2[CFG_SWAP] && r.cfg[7:6] == EXT_NONE) |->
      (rt0.src == SRC_PLAIN && rt0.store_idx == r.ctl0[2:0]);
  endproperty
  a_noswap: assert property (p_noswap)
    else $error("unswapped route altered");

  property p_amp;
    @(posedge aclk) disable iff (!aresetn)
    (r.cfg[7:6] == EXT_AMP && !r.cfg2[CFG_SWAP]) |->
      (amp_out_en && rt0.src == SRC_EXT1 && rt0.store_idx == r.ctl0[2:0]);
  endproperty
  a_amp: assert property (p_amp)
    else $error("amplifier mode wrong");

  property p_ext0;
    @(posedge aclk) disable iff (!aresetn)
    (!r.cfg2[CFG_SWAP] && r.cfg[7:6] == EXT_PIN0 && r.ctl0[5:3] == 3'h0 &&
     r.ctl0[2:0] == 3'h0) |-> (rt0.src == SRC_EXT0 && pin0_analog);
  endproperty
  a_ext0: assert property (p_ext0)
    else $error("extended pin zero not used");

  property p_ext_none;
    @(posedge aclk) disable iff (!aresetn)
    r.cfg[7:6] == EXT_NONE |-> !(pin0_analog || pin1_analog || amp_out_en);
  endproperty
  a_ext_none: assert property (p_ext_none)
    else $error("extended pins active with field zero");

  property p_ladder;
    @(posedge aclk) disable iff (!aresetn)
    !r.cfg[CFG_REF] |-> (!ladder_connect && r.busy == 2'h0);
  endproperty
  a_ladder: assert property (p_ladder)
    else $error("ladder connected or busy without reference");

  sequence s_finish0;
    ce && r.busy[0] && r.cnt0 == 6'h01 && r.cfg[CFG_REF];
  endsequence
  property p_done;
    @(posedge aclk) disable iff (!aresetn)
    s_finish0 |=> (irq0 && r.res0 == $past(conv_data0));
  endproperty
  a_done: assert property (p_done)
    else $error("completion not flagged");
endmodule

// ### verif/analog_side_model.sv
// analog side model: converter results keyed by the routed input source
`timescale 1ns/1ns
module analog_side_model
  import adc_aux_pkg::*;
(
  input wire logic aclk, // clock
  input wire route_t route0, // converter zero mux select
  input wire route_t route1, // converter one mux select
  input wire logic conv_active0, // converter zero busy
  input wire logic conv_active1, // converter one busy
  input wire logic ladder_connect, // reference ladder switch
  output logic [9:0] conv_data0, // converter zero result
  output logic [9:0] conv_data1 // converter one result
);
  // ========================================
  // idle pattern
  logic [9:0] churn = 10'h000;

  // changes every cycle through all 1024 values, so a result taken outside a conversion matches only by chance
  always_ff @(posedge aclk) begin
    churn <= churn + 10'h3B5;
  end

  // ========================================
  // results
  // a result names converter, source and channel; with the ladder off no
  // conversion is possible, so the lines only churn
  assign conv_data0 = (conv_active0 && ladder_connect) ?
    {3'h4, 1'b0, route0.src, route0.chan} : churn;
  assign conv_data1 = (conv_active1 && ladder_connect) ?
    {3'h4, 1'b1, route1.src, route1.chan} : ~churn;
endmodule

// ### verif/tb.sv
// testbench: register-level scenarios for the converter control block
`timescale 1ns/1ns
module tb;
  import adc_aux_pkg::*;
  logic aclk, aresetn, ce;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [9:0] conv_data0, conv_data1;
  route_t route0, route1;
  logic conv_active0, conv_active1, ladder_connect, amp_out_en;
  logic pin0_analog, pin1_analog, irq0, irq1;
  logic trig0;
  int err_total = 0;
  int n_compared = 0;
  src_t ext_src [4] = '{SRC_PLAIN, SRC_EXT0, SRC_EXT1, SRC_EXT1};
  logic [2:0] ext_ch [4] = '{3'h0, 3'h0, 3'h1, 3'h5};
  logic [2:0] ext_pins [4] = '{3'h0, 3'h1, 3'h2, 3'h6};
  logic [1:0] ports [3] = '{PORT_G15, PORT_G0, PORT_G2};
  src_t port_src [3] = '{SRC_G15, SRC_G0, SRC_G2};

  // ========================================
  // design and far side
  // short conversion keeps the run brief
  adc_aux_ctrl #(.CONV_LEN(3)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .conv_data0(conv_data0), .conv_data1(conv_data1),
    .ext_trig0(trig0), .ext_trig1(1'b0), .route0(route0),
    .route1(route1), .conv_active0(conv_active0),
    .conv_active1(conv_active1), .ladder_connect(ladder_connect),
    .amp_out_en(amp_out_en), .pin0_analog(pin0_analog),
    .pin1_analog(pin1_analog), .irq0(irq0), .irq1(irq1));

  analog_side_model far_side (
    .aclk(aclk), .route0(route0), .route1(route1),
    .conv_active0(conv_active0), .conv_active1(conv_active1),
    .ladder_connect(ladder_connect), .conv_data0(conv_data0),
    .conv_data1(conv_data1));

  // ========================================
  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic give_up();
    err_total++;
    summarize();
  endtask

  // ========================================
  // bus tasks: ready and valid are sampled at the falling edge, which
  // equals their value at the next rising edge since inputs move only there
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic pa, pw, ta, tw, hb;
    pa = 1'b1;
    pw = 1'b1;
    hb = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((pa || pw) && n < 50) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
      n++;
    end
    while (!hb && n < 100) begin
      @(negedge aclk);
      hb = bvalid;
      @(posedge aclk);
      n++;
    end
    bready <= 1'b0;
    if (!hb) give_up();
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    logic hit;
    hit = 1'b0;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hit && n < 50) begin
      @(negedge aclk);
      hit = arready;
      @(posedge aclk);
      n++;
    end
    arvalid <= 1'b0;
    hit = 1'b0;
    while (!hit && n < 100) begin
      @(negedge aclk);
      hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      n++;
    end
    rready <= 1'b0;
    if (!hit) give_up();
  endtask

  task automatic rcheck(input logic [7:0] a, input logic [31:0] mask,
                        input logic [31:0] exp);
    axi_read(a, rd, rs);
    check(rd & mask, exp);
  endtask

  // results are read only once the done request is up
  task automatic wait_done();
    int n;
    n = 0;
    while (irq0 !== 1'b1 && n < 200) begin
      @(negedge aclk);
      n++;
    end
    if (irq0 !== 1'b1) give_up();
  endtask

  // ========================================
  // clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ========================================
  // scenarios
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    trig0 = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // idle after reset, then an unmapped read
    rcheck(OFF_CFG, 32'hFFFFFFFF, 32'h0);
    check(ladder_connect, 1'b0);
    axi_read(8'h20, rd, rs);
    check(rd, 32'h0);
    check(rs, 2'h2);
    // every extended field code, with the reference connected
    for (int e = 0; e < 4; e++) begin
      axi_write(OFF_CTRL0, {29'h0, ext_ch[e]});
      axi_write(OFF_CFG, 32'h20 | (e << 6));
      check(ladder_connect, 1'b1);
      check({amp_out_en, pin1_analog, pin0_analog}, ext_pins[e]);
      check(route0.src, ext_src[e]);
    end
    check(route0.store_idx, 3'h5);
    // amplifier-mode conversion; reference set in an earlier write
    axi_write(OFF_CTRL0, 32'h45);
    wait_done();
    rcheck(OFF_RES0, 32'hFF, {26'h0, SRC_EXT1, 3'h5});
    axi_write(OFF_STAT, 32'h1);
    rcheck(OFF_STAT, 32'h1, 32'h0);
    // swap with each port code; both first registers equal
    axi_write(OFF_CTRL0, 32'h3);
    axi_write(OFF_CTRL1, 32'h3);
    for (int p = 0; p < 3; p++) begin
      axi_write(OFF_CFG2, 32'h10 | (ports[p] << 1));
      check({route0.src, route0.chan}, {port_src[p], 3'h3});
      check(route1.src, SRC_PLAIN);
    end
    // simultaneous start while both are idle
    axi_write(OFF_CFG2, 32'h96);
    wait_done();
    check(irq1, 1'b1);
    rcheck(OFF_RES0, 32'hFF, {26'h0, SRC_G2, 3'h3});
    rcheck(OFF_RES1, 32'hFF, {25'h0, 1'b1, SRC_PLAIN, 3'h3});
    rcheck(OFF_STAT, 32'hF, 32'h3);
    // swap off
    axi_write(OFF_CFG, 32'h20);
    axi_write(OFF_CFG2, 32'h06);
    check({route0.src, route0.chan}, {SRC_PLAIN, 3'h3});
    check(route1.src, SRC_PLAIN);
    // repeat mode keeps converting; bench reads on the same undivided clock
    axi_write(OFF_STAT, 32'h3);
    axi_write(OFF_CTRL0, 32'h4A);
    wait_done();
    check(conv_active0, 1'b1);
    rcheck(OFF_RES0, 32'hFF, 32'h02);
    axi_write(OFF_CTRL0, 32'h0A);
    check(conv_active0, 1'b0);
    // external trigger pin edge starts a one-shot conversion on channel four
    axi_write(OFF_STAT, 32'h1);
    axi_write(OFF_CTRL0, 32'h84);
    trig0 <= 1'b1;
    wait_done();
    @(posedge aclk);
    trig0 <= 1'b0;
    rcheck(OFF_RES0, 32'hFF, 32'h04);
    axi_write(OFF_CTRL0, 32'h04);
    // ladder off, cleared only while idle: a start must not run
    axi_write(OFF_CFG, 32'h0);
    check(ladder_connect, 1'b0);
    axi_write(OFF_CTRL0, 32'h43);
    check(conv_active0, 1'b0);
    rcheck(OFF_STAT, 32'hC, 32'h0);
    summarize();
  end
endmodule
